/* pkg/drive_pkg.sv */
package drive_pkg;

   // ==========================================================
   // clock and timing
   // ==========================================================
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned BLINK_MS      = 500;
   localparam int unsigned BLINK_CYCLES  = BLINK_MS * 1_000_000 / CLK_PERIOD_NS;

   // ==========================================================
   // frame identifiers
   // ==========================================================
   localparam logic [10:0] RX_ID_BASE = 11'h600;
   localparam logic [10:0] TX_ID_BASE = 11'h580;

   // ==========================================================
   // command bytes
   // ==========================================================
   localparam logic [7:0] CMD_WR_8     = 8'h2F;
   localparam logic [7:0] CMD_WR_16    = 8'h2B;
   localparam logic [7:0] CMD_WR_32    = 8'h23;
   localparam logic [7:0] CMD_WR_ACK   = 8'h60;
   localparam logic [7:0] CMD_RD_REQ   = 8'h40;
   localparam logic [7:0] CMD_RD_8     = 8'h4F;
   localparam logic [7:0] CMD_RD_16    = 8'h4B;
   localparam logic [7:0] CMD_RD_32    = 8'h43;
   localparam logic [7:0] CMD_ABORT    = 8'h80;

   // ==========================================================
   // abort codes
   // ==========================================================
   localparam logic [31:0] ABT_BAD_CMD   = 32'h0504_0001;
   localparam logic [31:0] ABT_READ_ONLY = 32'h0601_0002;
   localparam logic [31:0] ABT_NO_OBJECT = 32'h0602_0000;
   localparam logic [31:0] ABT_BAD_LEN   = 32'h0607_0010;
   localparam logic [31:0] ABT_NO_SUB    = 32'h0609_0011;
   localparam logic [31:0] ABT_STATE     = 32'h0800_0022;

   // ==========================================================
   // object indexes
   // ==========================================================
   localparam logic [15:0] IDX_DRIVE_COMMAND   = 16'h6040;
   localparam logic [15:0] IDX_STATE_REPORT    = 16'h6041;
   localparam logic [15:0] IDX_OPERATING_MODE  = 16'h6060;
   localparam logic [15:0] IDX_MEASURED_SPEED  = 16'h606C;
   localparam logic [15:0] IDX_RAMP_UP_RATE    = 16'h6083;
   localparam logic [15:0] IDX_RAMP_DOWN_RATE  = 16'h6084;
   localparam logic [15:0] IDX_SPEED_SETPOINT  = 16'h60FF;

   // ==========================================================
   // command values, mode value, state reports, reset values
   // ==========================================================
   localparam logic [15:0] DC_DISABLE    = 16'h0000;
   localparam logic [15:0] DC_QUICK_STOP = 16'h0002;
   localparam logic [15:0] DC_SHUTDOWN   = 16'h0006;
   localparam logic [15:0] DC_SWITCH_ON  = 16'h0007;
   localparam logic [15:0] DC_ENABLE_OP  = 16'h000F;
   localparam logic [7:0]  MODE_PROFILE_VELOCITY = 8'h03;
   localparam logic [15:0] SR_DISABLED   = 16'h0040;
   localparam logic [15:0] SR_ARMED      = 16'h0021;
   localparam logic [15:0] SR_SWITCHED   = 16'h0023;
   localparam logic [15:0] SR_OP_ENABLED = 16'h0027;
   localparam logic [15:0] SR_QUICK_STOP = 16'h0007;
   localparam logic [15:0] RST_COMMAND   = 16'h0000;
   localparam logic [7:0]  RST_MODE      = 8'h00;
   localparam logic [31:0] RST_RATE      = 32'h0000_0000;
   localparam logic [31:0] RST_SETPOINT  = 32'h0000_0000;

   // ==========================================================
   // operating and summary states
   // ==========================================================
   typedef enum logic [2:0] {
      ST_DISABLED   = 3'h0,
      ST_ARMED      = 3'h1,
      ST_SWITCHED   = 3'h3,
      ST_OP_ENABLED = 3'h2,
      ST_QUICK_STOP = 3'h6
   } drive_state_t;

   typedef enum logic [1:0] {
      MACRO_INIT = 2'h0,
      MACRO_IDLE = 2'h1,
      MACRO_RUN  = 2'h2,
      MACRO_STOP = 2'h3
   } macro_state_t;

endpackage

/* design/speed_ramp.sv */
`timescale 1ns/10ps
module speed_ramp #(
   parameter int unsigned CLK_HZ = drive_pkg::CLK_HZ
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        run_i,
   input  wire logic [31:0] target_i,
   input  wire logic [31:0] up_rate_i,
   input  wire logic [31:0] down_rate_i,
   output logic      [31:0] speed_o
);
   // ==========================================================
   // fractional step divider: one rpm step per CLK_HZ of accumulated rate
   // ==========================================================
   localparam logic [33:0] HZ = 34'(CLK_HZ);
   logic [33:0] acc_r;
   logic [33:0] acc_sum;
   logic        step;
   logic        away;
   logic [31:0] goal;

   // when run_i is low the goal collapses to zero
   assign goal    = run_i ? target_i : 32'h0000_0000;
   // rising magnitude uses the up rate, falling uses the down rate
   assign away    = (goal[31] == speed_o[31] || speed_o == 32'h0000_0000) &&
                    ($signed(goal) > $signed(speed_o)) == !goal[31];
   assign acc_sum = acc_r + {2'b00, away ? up_rate_i : down_rate_i};
   assign step    = acc_sum >= HZ;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_r <= 34'h0;
      end else if (speed_o == goal) begin
         acc_r <= 34'h0;
      end else if (step) begin
         acc_r <= (acc_sum - HZ >= HZ) ? 34'h0 : acc_sum - HZ;
      end else begin
         acc_r <= acc_sum;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         speed_o <= 32'h0000_0000;
      end else if (step && speed_o != goal) begin
         speed_o <= ($signed(goal) > $signed(speed_o)) ? speed_o + 32'h1 : speed_o - 32'h1;
      end
   end
endmodule // speed_ramp

/* design/state_blinker.sv */
`timescale 1ns/10ps
module state_blinker #(
   parameter int unsigned BLINK_CYCLES = drive_pkg::BLINK_CYCLES
) (
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   input  drive_pkg::macro_state_t      macro_i,
   output logic [1:0]                   led_o
);
   // ==========================================================
   // blink divider
   // ==========================================================
   logic [31:0] cnt_r;
   logic        phase_r;
   logic        tick;

   assign tick = (cnt_r == 32'(BLINK_CYCLES - 1));

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r <= 32'h0;
      end else begin
         cnt_r <= tick ? 32'h0 : cnt_r + 32'h1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_r <= 1'b0;
      end else if (tick) begin
         phase_r <= ~phase_r;
      end
   end

   // ==========================================================
   // indicator pattern: bit 0 green, bit 1 red
   // ==========================================================
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         led_o <= 2'b01;
      end else begin
         case (macro_i)
            drive_pkg::MACRO_INIT: led_o <= {phase_r, ~phase_r};
            drive_pkg::MACRO_IDLE: led_o <= {1'b0, phase_r};
            drive_pkg::MACRO_RUN:  led_o <= 2'b01;
            drive_pkg::MACRO_STOP: led_o <= 2'b10;
            default:               led_o <= 2'b00;
         endcase
      end
   end
endmodule // state_blinker

/* design/drive_state_sdo_sequencer.sv */
`timescale 1ns/10ps
// Overview of operation
// - accepted expedited write acknowledged with 0x60, index, sub-index, zero data
// - writes use 2F, 2B, 23 for 8, 16, 32 bit; data low byte first
// - command 6 from disabled gives armed; then 7 gives switched on
// - switched on reports 0x0023
// - read request 40; answer 4B for 16 bit, 43 for 32 bit
// - command 15 from switched on enables operation with motor powered
// - operation enabled reports 0x0027
// - target speed written as 32 bit rpm; drive follows it in profile velocity mode (mode 3) only
// - measured speed returned as 32 bit value on read
// - setpoint zero in operation: ramp down with down rate, torque kept
// - command 7 from operation enabled returns to switched on, torque off
// - command 0 gives disabled, no torque, reports 0x0040
// - command 2 from operation enabled gives quick stop active with torque, reports 0x0007
// - after start-up rest disabled; indicator blinks alternately
// - summary states: disabled init, switched on idle, operation run, quick stop stop
// - responses sent on 0x580 plus node number
module drive_state_sdo_sequencer #(
   parameter int unsigned CLK_HZ       = drive_pkg::CLK_HZ,
   parameter int unsigned BLINK_CYCLES = drive_pkg::BLINK_CYCLES
) (
   input  wire logic        CORE_CLK_I,
   input  wire logic        NRST_I,
   input  wire logic [6:0]  NODE_ID_I,
   input  wire logic        REQ_VALID_I,
   input  wire logic [10:0] REQ_ID_I,
   input  wire logic [63:0] REQ_DATA_I,
   output logic             REQ_READY_O,
   output logic             RSP_VALID_O,
   output logic      [10:0] RSP_ID_O,
   output logic      [63:0] RSP_DATA_O,
   input  wire logic        RSP_READY_I,
   input  wire logic [31:0] MEAS_SPEED_I,
   output logic             TORQUE_EN_O,
   output logic      [31:0] SPEED_CMD_O,
   output logic      [1:0]  MACRO_STATE_O,
   output logic      [1:0]  LED_O
);

   // ==========================================================
   // helpers
   // ==========================================================
   function automatic logic [63:0] frame(input logic [7:0]  cmd,
                                         input logic [15:0] idx,
                                         input logic [7:0]  sub,
                                         input logic [31:0] dat);
      frame = {dat, sub, idx[15:8], idx[7:0], cmd};
   endfunction

   function automatic logic [15:0] report(input drive_pkg::drive_state_t st);
      case (st)
         drive_pkg::ST_DISABLED:   report = drive_pkg::SR_DISABLED;
         drive_pkg::ST_ARMED:      report = drive_pkg::SR_ARMED;
         drive_pkg::ST_SWITCHED:   report = drive_pkg::SR_SWITCHED;
         drive_pkg::ST_OP_ENABLED: report = drive_pkg::SR_OP_ENABLED;
         drive_pkg::ST_QUICK_STOP: report = drive_pkg::SR_QUICK_STOP;
         default:                  report = drive_pkg::SR_DISABLED;
      endcase
   endfunction

   function automatic drive_pkg::drive_state_t step_state(
         input drive_pkg::drive_state_t st, input logic [15:0] dc);
      step_state = st;
      if (dc == drive_pkg::DC_DISABLE) begin
         step_state = drive_pkg::ST_DISABLED;
      end else begin
         case (st)
            drive_pkg::ST_DISABLED: begin
               if (dc == drive_pkg::DC_SHUTDOWN) step_state = drive_pkg::ST_ARMED;
            end
            drive_pkg::ST_ARMED: begin
               if (dc == drive_pkg::DC_SWITCH_ON) step_state = drive_pkg::ST_SWITCHED;
            end
            drive_pkg::ST_SWITCHED: begin
               if (dc == drive_pkg::DC_ENABLE_OP) step_state = drive_pkg::ST_OP_ENABLED;
               else if (dc == drive_pkg::DC_SHUTDOWN) step_state = drive_pkg::ST_ARMED;
            end
            drive_pkg::ST_OP_ENABLED: begin
               if (dc == drive_pkg::DC_SWITCH_ON) step_state = drive_pkg::ST_SWITCHED;
               else if (dc == drive_pkg::DC_QUICK_STOP) step_state = drive_pkg::ST_QUICK_STOP;
               else if (dc == drive_pkg::DC_SHUTDOWN) step_state = drive_pkg::ST_ARMED;
            end
            drive_pkg::ST_QUICK_STOP: begin
               if (dc == drive_pkg::DC_ENABLE_OP) step_state = drive_pkg::ST_OP_ENABLED;
            end
            default: step_state = drive_pkg::ST_DISABLED;
         endcase
      end
   endfunction

   // ==========================================================
   // request fields
   // ==========================================================
   logic [10:0] rx_id;
   logic [7:0]  req_cmd;
   logic [15:0] req_idx;
   logic [7:0]  req_sub;
   logic [31:0] req_dat;
   logic        take;

   assign rx_id   = drive_pkg::RX_ID_BASE + {4'h0, NODE_ID_I};
   assign req_cmd = REQ_DATA_I[7:0];
   // index and data low byte first
   assign req_idx = {REQ_DATA_I[23:16], REQ_DATA_I[15:8]};
   assign req_sub = REQ_DATA_I[31:24];
   assign req_dat = REQ_DATA_I[63:32];

   logic rsp_valid_r;
   assign REQ_READY_O = ~rsp_valid_r;
   assign take        = REQ_VALID_I && !rsp_valid_r && (REQ_ID_I == rx_id);

   // ==========================================================
   // held objects and state
   // ==========================================================
   drive_pkg::drive_state_t state_r;
   drive_pkg::drive_state_t state_nxt;
   logic [15:0] command_r;
   logic [7:0]  mode_r;
   logic [31:0] up_rate_r;
   logic [31:0] down_rate_r;
   logic [31:0] setpoint_r;

   // ==========================================================
   // request decode
   // ==========================================================
   logic        is_wr;
   logic        wr_ok;
   logic [31:0] abort_code;
   logic [7:0]  rd_cmd;
   logic [31:0] rd_val;
   logic        known;
   logic [7:0]  obj_wr_cmd;
   logic        obj_ro;

   assign is_wr = (req_cmd == drive_pkg::CMD_WR_8) ||
                  (req_cmd == drive_pkg::CMD_WR_16) ||
                  (req_cmd == drive_pkg::CMD_WR_32);

   always_comb begin
      known      = 1'b1;
      obj_ro     = 1'b0;
      obj_wr_cmd = drive_pkg::CMD_WR_32;
      rd_cmd     = drive_pkg::CMD_RD_32;
      rd_val     = 32'h0000_0000;
      case (req_idx)
         drive_pkg::IDX_DRIVE_COMMAND: begin
            obj_wr_cmd = drive_pkg::CMD_WR_16;
            rd_cmd     = drive_pkg::CMD_RD_16;
            rd_val     = {16'h0000, command_r};
         end
         drive_pkg::IDX_STATE_REPORT: begin
            obj_ro     = 1'b1;
            obj_wr_cmd = drive_pkg::CMD_WR_16;
            rd_cmd     = drive_pkg::CMD_RD_16;
            rd_val     = {16'h0000, report(state_r)};
         end
         drive_pkg::IDX_OPERATING_MODE: begin
            obj_wr_cmd = drive_pkg::CMD_WR_8;
            rd_cmd     = drive_pkg::CMD_RD_8;
            rd_val     = {24'h00_0000, mode_r};
         end
         drive_pkg::IDX_MEASURED_SPEED: begin
            obj_ro = 1'b1;
            rd_val = MEAS_SPEED_I;
         end
         drive_pkg::IDX_RAMP_UP_RATE:   rd_val = up_rate_r;
         drive_pkg::IDX_RAMP_DOWN_RATE: rd_val = down_rate_r;
         drive_pkg::IDX_SPEED_SETPOINT: rd_val = setpoint_r;
         default: known = 1'b0;
      endcase
   end

   // priority: bad command, unknown object, sub-index, access, size, state
   always_comb begin
      abort_code = 32'h0000_0000;
      if (!is_wr && req_cmd != drive_pkg::CMD_RD_REQ) begin
         abort_code = drive_pkg::ABT_BAD_CMD;
      end else if (!known) begin
         abort_code = drive_pkg::ABT_NO_OBJECT;
      end else if (req_sub != 8'h00) begin
         abort_code = drive_pkg::ABT_NO_SUB;
      end else if (is_wr && obj_ro) begin
         abort_code = drive_pkg::ABT_READ_ONLY;
      end else if (is_wr && req_cmd != obj_wr_cmd) begin
         abort_code = drive_pkg::ABT_BAD_LEN;
      end else if (is_wr && req_idx == drive_pkg::IDX_OPERATING_MODE &&
                   state_r == drive_pkg::ST_OP_ENABLED) begin
         abort_code = drive_pkg::ABT_STATE;
      end
   end

   assign wr_ok = take && is_wr && (abort_code == 32'h0000_0000);

   // ==========================================================
   // held settings
   // ==========================================================
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         command_r <= drive_pkg::RST_COMMAND;
      end else if (wr_ok && req_idx == drive_pkg::IDX_DRIVE_COMMAND) begin
         command_r <= req_dat[15:0];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mode_r <= drive_pkg::RST_MODE;
      end else if (wr_ok && req_idx == drive_pkg::IDX_OPERATING_MODE) begin
         mode_r <= req_dat[7:0];
      end
   end

   // ramp rates held for the ramp
   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         up_rate_r   <= drive_pkg::RST_RATE;
         down_rate_r <= drive_pkg::RST_RATE;
      end else if (wr_ok && req_idx == drive_pkg::IDX_RAMP_UP_RATE) begin
         up_rate_r <= req_dat;
      end else if (wr_ok && req_idx == drive_pkg::IDX_RAMP_DOWN_RATE) begin
         down_rate_r <= req_dat;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         setpoint_r <= drive_pkg::RST_SETPOINT;
      end else if (wr_ok && req_idx == drive_pkg::IDX_SPEED_SETPOINT) begin
         setpoint_r <= req_dat;
      end
   end

   // ==========================================================
   // operating state
   // ==========================================================
   always_comb begin
      state_nxt = state_r;
      if (wr_ok && req_idx == drive_pkg::IDX_DRIVE_COMMAND) begin
         state_nxt = step_state(state_r, req_dat[15:0]);
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_r <= drive_pkg::ST_DISABLED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // response
   // ==========================================================
   logic [10:0] rsp_id_r;
   logic [63:0] rsp_data_r;

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rsp_valid_r <= 1'b0;
      end else if (take) begin
         rsp_valid_r <= 1'b1;
      end else if (RSP_READY_I) begin
         rsp_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rsp_id_r   <= 11'h000;
         rsp_data_r <= 64'h0;
      end else if (take) begin
         rsp_id_r <= drive_pkg::TX_ID_BASE + {4'h0, NODE_ID_I};
         if (abort_code != 32'h0000_0000) begin
            rsp_data_r <= frame(drive_pkg::CMD_ABORT, req_idx, req_sub, abort_code);
         end else if (is_wr) begin
            rsp_data_r <= frame(drive_pkg::CMD_WR_ACK, req_idx, req_sub, 32'h0000_0000);
         end else begin
            rsp_data_r <= frame(rd_cmd, req_idx, req_sub, rd_val);
         end
      end
   end

   assign RSP_VALID_O = rsp_valid_r;
   assign RSP_ID_O    = rsp_id_r;
   assign RSP_DATA_O  = rsp_data_r;

   // ==========================================================
   // power stage and speed profile
   // ==========================================================
   logic        powered;
   logic        follow;
   logic [31:0] ramp_speed;
   logic        torque_r;
   logic [31:0] speed_cmd_r;

   // torque in operation and quick stop only
   assign powered = (state_r == drive_pkg::ST_OP_ENABLED) ||
                    (state_r == drive_pkg::ST_QUICK_STOP);
   // follow setpoint only in profile velocity operation
   assign follow  = (state_r == drive_pkg::ST_OP_ENABLED) &&
                    (mode_r == drive_pkg::MODE_PROFILE_VELOCITY);

   // zero setpoint ramps with down rate, torque kept
   speed_ramp #(
      .CLK_HZ      (CLK_HZ)
   ) u_ramp (
      .clk_i       (CORE_CLK_I),
      .nrst_i      (NRST_I),
      .run_i       (follow),
      .target_i    (setpoint_r),
      .up_rate_i   (up_rate_r),
      .down_rate_i (down_rate_r),
      .speed_o     (ramp_speed)
   );

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         torque_r    <= 1'b0;
         speed_cmd_r <= 32'h0000_0000;
      end else begin
         torque_r    <= powered;
         speed_cmd_r <= powered ? ramp_speed : 32'h0000_0000;
      end
   end

   assign TORQUE_EN_O = torque_r;
   assign SPEED_CMD_O = speed_cmd_r;

   // ==========================================================
   // summary state and indicator
   // ==========================================================
   drive_pkg::macro_state_t macro_r;

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         macro_r <= drive_pkg::MACRO_INIT;
      end else begin
         case (state_r)
            drive_pkg::ST_SWITCHED:   macro_r <= drive_pkg::MACRO_IDLE;
            drive_pkg::ST_OP_ENABLED: macro_r <= drive_pkg::MACRO_RUN;
            drive_pkg::ST_QUICK_STOP: macro_r <= drive_pkg::MACRO_STOP;
            default:                  macro_r <= drive_pkg::MACRO_INIT;
         endcase
      end
   end

   assign MACRO_STATE_O = macro_r;

   state_blinker #(
      .BLINK_CYCLES (BLINK_CYCLES)
   ) u_led (
      .clk_i        (CORE_CLK_I),
      .nrst_i       (NRST_I),
      .macro_i      (macro_r),
      .led_o        (LED_O)
   );

endmodule // drive_state_sdo_sequencer

/* sim/drive_sdo_checker.sv */
`timescale 1ns/10ps
module drive_sdo_checker (
   input wire logic        CORE_CLK_I,
   input wire logic        NRST_I,
   input wire logic        REQ_VALID_I,
   input wire logic        REQ_READY_O,
   input wire logic        RSP_VALID_O,
   input wire logic        RSP_READY_I,
   input wire logic        TORQUE_EN_O,
   input wire logic [6:0]  NODE_ID_I,
   input wire logic [10:0] REQ_ID_I,
   input wire logic [10:0] RSP_ID_O,
   input wire logic [63:0] RSP_DATA_O,
   input wire logic [31:0] SPEED_CMD_O,
   input wire logic [1:0]  MACRO_STATE_O,
   input wire logic [1:0]  LED_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);
   wire logic take = REQ_VALID_I && REQ_READY_O && REQ_ID_I == 11'h600 + NODE_ID_I;
   rsp_delay_a: assert property (take |=> RSP_VALID_O)
      else $error("no answer after take");
   busy_gate_a: assert property (REQ_READY_O == !RSP_VALID_O)
      else $error("ready while answer pending");
   rsp_hold_a: assert property (RSP_VALID_O && !RSP_READY_I |=> RSP_VALID_O && $stable(RSP_DATA_O))
      else $error("answer dropped or changed");
   rsp_id_a: assert property (RSP_VALID_O |-> RSP_ID_O == 11'h580 + NODE_ID_I)
      else $error("wrong answer identifier");
   foreign_id_a: assert property (REQ_VALID_I && REQ_READY_O && !take |=> !RSP_VALID_O)
      else $error("answered a foreign frame");
   macro_torque_a: assert property (TORQUE_EN_O == MACRO_STATE_O[1])
      else $error("torque and summary state disagree");
   idle_speed_a: assert property (!TORQUE_EN_O && $past(!TORQUE_EN_O) |-> SPEED_CMD_O == 32'h0)
      else $error("speed command without torque");
   ramp_step_a: assert property (TORQUE_EN_O && $past(TORQUE_EN_O) && $changed(SPEED_CMD_O)
      |-> SPEED_CMD_O - $past(SPEED_CMD_O) inside {32'h1, 32'hFFFF_FFFF}) else $error("ramp jumped");
   init_blink_a: assert property ((MACRO_STATE_O == 2'h0) [*3] |-> LED_O inside {2'h1, 2'h2})
      else $error("indicator not alternating");
   cover property (take);
   cover property ($rose(TORQUE_EN_O));
   cover property (MACRO_STATE_O == 2'h3);
endmodule // drive_sdo_checker
bind drive_state_sdo_sequencer drive_sdo_checker u_drive_sdo_checker (.*);

/* sim/sdo_master.sv */
`timescale 1ns/10ps
module sdo_master (
   input  wire logic        clk_i,
   input  wire logic        ready_i,
   output logic             valid_o = 1'b0,
   output logic      [10:0] id_o = 11'h0,
   output logic      [63:0] data_o = 64'h0
);
   // frame held until the edge that takes it; released bytes show the inverse
   task automatic send(input logic [10:0] id, input logic [63:0] d);
      @(negedge clk_i);
      valid_o = 1'b1;
      id_o    = id;
      data_o  = d;
      @(posedge clk_i);
      while (ready_i !== 1'b1) @(posedge clk_i);
      @(negedge clk_i);
      valid_o = 1'b0;
      data_o  = ~d;
   endtask
endmodule // sdo_master

/* sim/tb_drive_state_sdo_sequencer.sv */
`timescale 1ns/10ps
module tb_drive_state_sdo_sequencer;
   logic        CORE_CLK_I = 1'b0, NRST_I = 1'b0, RSP_READY_I = 1'b0;
   logic        REQ_VALID_I, REQ_READY_O, RSP_VALID_O, TORQUE_EN_O;
   logic [6:0]  NODE_ID_I;
   logic [10:0] REQ_ID_I, RSP_ID_O, own_id;
   logic [63:0] REQ_DATA_I, RSP_DATA_O, exp_q[$];
   logic [31:0] MEAS_SPEED_I, SPEED_CMD_O, qs[4] = '{32'h6, 32'h7, 32'hF, 32'h2};
   logic [1:0]  MACRO_STATE_O, LED_O;
   int          num_errors = 0, n_compared = 0, seed = 10, cycles = 0;
   initial forever #4 CORE_CLK_I = ~CORE_CLK_I;
   drive_state_sdo_sequencer #(.CLK_HZ(100), .BLINK_CYCLES(4)) u_drive_state_sdo_sequencer (.*);
   sdo_master u_sdo_master (.clk_i(CORE_CLK_I), .ready_i(REQ_READY_O), .valid_o(REQ_VALID_I),
      .id_o(REQ_ID_I), .data_o(REQ_DATA_I));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic op(input logic [7:0] c, input logic [15:0] i, input logic [31:0] d,
                     input logic [7:0] rc, input logic [31:0] rd);
      exp_q.push_back({rd, 8'h00, i, rc});
      u_sdo_master.send(own_id, {d, 8'h00, i, c});
   endtask
   task automatic step(input string name, input logic [1:0] m, input logic t);
      for (int k = 0; k < 60 && exp_q.size() > 0; k++) @(posedge CORE_CLK_I);
      repeat (3) @(negedge CORE_CLK_I);
      check("summary", 64'(MACRO_STATE_O), 64'(m));
      check("torque", 64'(TORQUE_EN_O), 64'(t));
      $display("test %s done", name);
   endtask
   always @(negedge CORE_CLK_I) RSP_READY_I <= 1'($random(seed));
   always @(posedge CORE_CLK_I) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         results();
      end else if ((RSP_VALID_O & RSP_READY_I) === 1'b1) begin
         check("answer id", 64'(RSP_ID_O), 64'(11'h580 + 11'(NODE_ID_I)));
         check("answer", RSP_DATA_O, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      end
   end
   initial begin
      NODE_ID_I = 7'($random(seed));
      MEAS_SPEED_I = $random(seed);
      own_id = 11'h600 + 11'(NODE_ID_I);
      repeat (3) @(negedge CORE_CLK_I);
      NRST_I = 1'b1;
      op(8'h2F, 16'h6060, 32'h3, 8'h60, 32'h0);
      op(8'h2B, 16'h6040, 32'h6, 8'h60, 32'h0);
      op(8'h2B, 16'h6040, 32'h7, 8'h60, 32'h0);
      op(8'h40, 16'h6041, 32'h0, 8'h4B, 32'h23);
      step("switch on", 2'h1, 1'b0);
      op(8'h23, 16'h6083, 32'h32, 8'h60, 32'h0);
      op(8'h23, 16'h6084, 32'h32, 8'h60, 32'h0);
      op(8'h40, 16'h6084, 32'h0, 8'h43, 32'h32);
      op(8'h2B, 16'h6040, 32'hF, 8'h60, 32'h0);
      op(8'h40, 16'h6041, 32'h0, 8'h4B, 32'h27);
      op(8'h2F, 16'h6060, 32'h3, 8'h80, 32'h0800_0022);
      op(8'h23, 16'h60FF, 32'h14, 8'h60, 32'h0);
      op(8'h40, 16'h606C, 32'h0, 8'h43, MEAS_SPEED_I);
      u_sdo_master.send(own_id + 11'h1, {32'h0, 8'h00, 16'h6040, 8'h2B});
      step("run", 2'h2, 1'b1);
      repeat (100) @(negedge CORE_CLK_I);
      check("speed", 64'(SPEED_CMD_O), 64'h14);
      op(8'h23, 16'h60FF, 32'h0, 8'h60, 32'h0);
      repeat (100) @(negedge CORE_CLK_I);
      check("speed", 64'(SPEED_CMD_O), 64'h0);
      step("ramp down", 2'h2, 1'b1);
      op(8'h2B, 16'h6040, 32'h7, 8'h60, 32'h0);
      op(8'h40, 16'h6041, 32'h0, 8'h4B, 32'h23);
      step("torque off", 2'h1, 1'b0);
      op(8'h2B, 16'h6040, 32'h0, 8'h60, 32'h0);
      op(8'h2B, 16'h6040, 32'h2, 8'h60, 32'h0);
      op(8'h40, 16'h6041, 32'h0, 8'h4B, 32'h40);
      step("disable", 2'h0, 1'b0);
      foreach (qs[k]) op(8'h2B, 16'h6040, qs[k], 8'h60, 32'h0);
      op(8'h40, 16'h6041, 32'h0, 8'h4B, 32'h07);
      op(8'h40, 16'h6040, 32'h0, 8'h4B, 32'h2);
      op(8'h2B, 16'h6041, 32'h0, 8'h80, 32'h0601_0002);
      op(8'h40, 16'h6060, 32'h0, 8'h4F, 32'h3);
      op(8'h23, 16'h6040, 32'h0, 8'h80, 32'h0607_0010);
      op(8'hA0, 16'h6040, 32'h0, 8'h80, 32'h0504_0001);
      op(8'h2B, 16'h6000, 32'h0, 8'h80, 32'h0602_0000);
      step("quick stop", 2'h3, 1'b1);
      NRST_I = 1'b0;
      repeat (3) @(negedge CORE_CLK_I);
      NRST_I = 1'b1;
      op(8'h40, 16'h6041, 32'h0, 8'h4B, 32'h40);
      op(8'h40, 16'h6083, 32'h0, 8'h43, 32'h0);
      step("reset", 2'h0, 1'b0);
      check("pending", 64'(exp_q.size()), 64'h0);
      results();
   end
endmodule // tb_drive_state_sdo_sequencer
